// ### logic/fiber_an_pkg.sv
// package: register map, field layout, resets and carriers for fiber page registers
package fiber_an_pkg;

  // ----------------------------------------------------------------
  // register indices and addressing
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_AN_EXPANSION    = 12'hc06;
  localparam logic [11:0] IDX_LOCAL_NP        = 12'hc07;
  localparam logic [11:0] IDX_PARTNER_NP      = 12'hc08;
  localparam logic [11:0] IDX_FIBER_CTRL0     = 12'hc10;
  localparam logic [11:0] IDX_IRQ_MASK        = 12'hc18;
  localparam logic [11:0] IDX_IRQ_PENDING     = 12'hc19;
  localparam logic [11:0] IDX_IRQ_CLEAR       = 12'hc1a;
  localparam int          ADDR_W              = 14;
  localparam int          IDX_LSB             = 2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EXP_PARTNER_NP_BIT   = 3;
  localparam int EXP_LOCAL_NP_BIT     = 2;
  localparam int EXP_PAGE_RX_BIT      = 1;
  localparam int EXP_PARTNER_AN_BIT   = 0;
  localparam int NP_MORE_BIT          = 15;
  localparam int NP_FORMAT_BIT        = 13;
  localparam int NP_ACK2_BIT          = 12;
  localparam int NP_TOGGLE_BIT        = 11;
  localparam int SIGDET_IGNORE_BIT    = 9;
  localparam int IRQ_N                = 10;

  // ----------------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [15:0] LOCAL_NP_RESET    = 16'h2001;
  localparam logic [15:0] LOCAL_NP_WMASK    = 16'hb7ff;
  localparam logic [15:0] IRQ_MASK_RESET    = 16'h03ff;
  localparam logic [15:0] IRQ_MASK_WMASK    = 16'h03ff;
  localparam logic [15:0] CTRL0_WMASK       = 16'h0200;
  localparam logic [15:0] ZERO16            = 16'h0000;
  localparam logic [9:0]  IRQ_ZERO          = 10'h000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        more_pages_flag;
    logic        rsvd;
    logic        page_format;
    logic        comply_ack;
    logic        toggle;
    logic [10:0] code_field;
  } np_word_t;

  typedef struct packed {
    logic      base_page_rx;
    logic      next_page_rx;
    np_word_t  rx_word;
    logic      enable_state;
    logic      sgmii_mode;
    logic      tx_done;
  } an_event_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage

// ### logic/fiber_autoneg_page_regs.sv
// top: fiber auto-negotiation page registers behind an avalon-mm slave
// Contract
// - partner next-page capable sets on base page with flag, clears in enable state
// - local next-page capable reads one in 1000base-x, zero in sgmii
// - partner negotiation capable sets on any base page, clears in enable state
// - page received latches on any page, cleared by reading expansion register
// - local word top bit is writable more-pages flag
// - local word bit 13 writable page format, resets to one
// - local word bit 12 writable comply acknowledge
// - local toggle read-only, flips after each transmitted page, resets zero
// - local eleven-bit code field writable, resets to one
// - each received partner next page captured into read-only word
// - captured partner toggle reads inverse of prior codeword toggle; the code stores the received toggle unchanged
// - writable bit selects signal-detect pin use or ignore
// - ten writable enable bits, all enabled after reset, far-end fault bit 9
// - enable bits 8..5 gate fifo full and empty interrupts, both modes
// - enable bits 4..0 gate link, fault, resolution, next page, base page
// - pending status bits set per event, cleared on status read
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
module fiber_autoneg_page_regs
  import fiber_an_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire an_event_t           an_event,
  input  wire logic [IRQ_N-1:0]    irq_events,
  output logic                     sigdet_pin_ignore,
  output np_word_t                 local_np_word,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bus_state_t       bus_q;
  logic             partner_np_capable_q;
  logic             partner_negotiation_capable_q;
  logic             page_received_latch_q;
  logic             local_np_capable_q;
  logic [15:0]      local_np_q;
  logic [15:0]      partner_np_q;
  logic [15:0]      ctrl0_q;
  logic [15:0]      mask_q;
  logic [IRQ_N-1:0] pending_q;
  logic             irq_q;
  logic [31:0]      rdata_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic [11:0] idx       = avs_address[ADDR_W-1:IDX_LSB];
  wire logic        access    = (bus_q == BUS_IDLE) && (avs_read || avs_write);
  wire logic        rd_go     = access && avs_read;
  wire logic        wr_go     = access && avs_write;
  wire logic [15:0] be_mask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [15:0] wdata     = avs_writedata[15:0];
  wire logic        wr_lnp    = wr_go && (idx == IDX_LOCAL_NP);
  wire logic        wr_ctrl   = wr_go && (idx == IDX_FIBER_CTRL0);
  wire logic        wr_mask   = wr_go && (idx == IDX_IRQ_MASK);
  wire logic        wr_clr    = wr_go && (idx == IDX_IRQ_CLEAR);
  wire logic        rd_exp    = rd_go && (idx == IDX_AN_EXPANSION);
  wire logic        rd_pend   = rd_go && (idx == IDX_IRQ_PENDING);

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  wire logic [15:0] lnp_wm    = LOCAL_NP_WMASK & be_mask;
  wire logic [15:0] lnp_wr    = (local_np_q & ~lnp_wm) | (wdata & lnp_wm);
  // toggle is hardware-owned; a transmitted page flips it for the next one
  wire logic        tog_d     = an_event.tx_done ? ~local_np_q[NP_TOGGLE_BIT]
                                                 : local_np_q[NP_TOGGLE_BIT];
  wire logic [15:0] lnp_d     = {lnp_wr[15:NP_TOGGLE_BIT+1], tog_d, lnp_wr[NP_TOGGLE_BIT-1:0]};
  wire logic [15:0] ctrl_wm   = CTRL0_WMASK & be_mask;
  wire logic [15:0] ctrl_d    = (ctrl0_q & ~ctrl_wm) | (wdata & ctrl_wm);
  wire logic [15:0] mask_wm   = IRQ_MASK_WMASK & be_mask;
  wire logic [15:0] mask_d    = (mask_q & ~mask_wm) | (wdata & mask_wm);
  wire np_word_t    rx_w      = an_event.rx_word;
  // received toggle is stored as captured, reserved bit forced to zero
  wire logic [15:0] pnp_d     = {rx_w.more_pages_flag, 1'b0, rx_w.page_format,
                                 rx_w.comply_ack, rx_w.toggle, rx_w.code_field};
  wire logic        any_page  = an_event.base_page_rx || an_event.next_page_rx;
  wire logic [IRQ_N-1:0] clr_bits = wr_clr ? wdata[IRQ_N-1:0] : IRQ_ZERO;
  wire logic [IRQ_N-1:0] rd_bits  = rd_pend ? pending_q : IRQ_ZERO;
  // set wins over read-clear and write-clear in the same cycle
  wire logic [IRQ_N-1:0] pend_d   = (pending_q & ~clr_bits & ~rd_bits) | irq_events;
  // mask_d follows write data on every cycle, so it only counts while the mask is written
  wire logic [15:0] mask_nx   = wr_mask ? mask_d : mask_q;
  wire logic [IRQ_N-1:0] en_pend  = pend_d & mask_nx[IRQ_N-1:0];
  wire logic        irq_d     = |en_pend;

  wire logic [15:0] exp_word  = {12'h000, partner_np_capable_q, local_np_capable_q,
                                 page_received_latch_q, partner_negotiation_capable_q};
  wire logic        mapped    = (idx == IDX_AN_EXPANSION) || (idx == IDX_LOCAL_NP) ||
                                (idx == IDX_PARTNER_NP)   || (idx == IDX_FIBER_CTRL0) ||
                                (idx == IDX_IRQ_MASK)     || (idx == IDX_IRQ_PENDING);
  wire logic [15:0] rd_mux    = !mapped                  ? ZERO16 :
                                (idx == IDX_AN_EXPANSION) ? exp_word :
                                (idx == IDX_LOCAL_NP)     ? local_np_q :
                                (idx == IDX_PARTNER_NP)   ? partner_np_q :
                                (idx == IDX_FIBER_CTRL0)  ? ctrl0_q :
                                (idx == IDX_IRQ_MASK)     ? mask_q :
                                {6'h00, pending_q};

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, answer in the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bus_q           <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      rdata_q         <= 32'h0000_0000;
    end else begin
      unique case (bus_q)
        BUS_IDLE: begin
          if (access) begin
            bus_q           <= BUS_ANSWER;
            avs_waitrequest <= 1'b0;
            rdata_q         <= {16'h0000, rd_mux};
          end else begin
            avs_waitrequest <= 1'b1;
          end
        end
        BUS_ANSWER: begin
          bus_q           <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end
  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // expansion status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      partner_np_capable_q          <= 1'b0;
      partner_negotiation_capable_q <= 1'b0;
      page_received_latch_q         <= 1'b0;
      local_np_capable_q            <= 1'b0;
    end else begin
      local_np_capable_q <= ~an_event.sgmii_mode;
      // enable state clears both capability bits; a base page in that cycle still sets them, the next-page bit only with the flag
      if (an_event.base_page_rx && rx_w.more_pages_flag) begin
        partner_np_capable_q <= 1'b1;
      end else if (an_event.enable_state) begin
        partner_np_capable_q <= 1'b0;
      end
      if (an_event.base_page_rx) begin
        partner_negotiation_capable_q <= 1'b1;
      end else if (an_event.enable_state) begin
        partner_negotiation_capable_q <= 1'b0;
      end
      if (any_page) begin
        page_received_latch_q <= 1'b1;
      end else if (rd_exp) begin
        page_received_latch_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // page words, control, mask, pending
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      local_np_q   <= LOCAL_NP_RESET;
      partner_np_q <= ZERO16;
      ctrl0_q      <= ZERO16;
      mask_q       <= IRQ_MASK_RESET;
      pending_q    <= IRQ_ZERO;
      irq_q        <= 1'b0;
    end else begin
      local_np_q <= wr_lnp ? lnp_d : {local_np_q[15:NP_TOGGLE_BIT+1], tog_d,
                                      local_np_q[NP_TOGGLE_BIT-1:0]};
      if (an_event.next_page_rx) begin
        partner_np_q <= pnp_d;
      end
      if (wr_ctrl) begin
        ctrl0_q <= ctrl_d;
      end
      if (wr_mask) begin
        mask_q <= mask_d;
      end
      pending_q <= pend_d;
      irq_q     <= irq_d;
    end
  end

  assign sigdet_pin_ignore = ctrl0_q[SIGDET_IGNORE_BIT];
  assign local_np_word     = local_np_q;
  assign irq               = irq_q;

endmodule // fiber_autoneg_page_regs

// ### verif/fiber_an_assertions.sv
// checker: port assertions of the fiber page registers
`timescale 1ns/1ns
module fiber_an_assertions
  import fiber_an_pkg::*;
(
  input wire logic             clk_sys,
  input wire logic             reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_writedata,
  input wire logic [3:0]       avs_byteenable,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  input wire an_event_t        an_event,
  input wire logic [IRQ_N-1:0] irq_events,
  input wire logic             sigdet_pin_ignore,
  input wire np_word_t         local_np_word,
  input wire logic             irq
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire logic [11:0] idx = avs_address[13:2];
  wire logic        wr_ok = avs_write && !avs_waitrequest && avs_byteenable[1:0] == 2'b11;
  sequence s_taken; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
  AST_ANSWER: assert property (s_taken |=> s_answer)
    else $error("access not answered after one wait cycle");
  AST_RD_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_RSVD: assert property (local_np_word.rsvd == 1'b0)
    else $error("local word reserved bit set");
  AST_WR_LOCAL: assert property (wr_ok && idx == IDX_LOCAL_NP |->
    (local_np_word & LOCAL_NP_WMASK) == (avs_writedata[15:0] & LOCAL_NP_WMASK))
    else $error("local word write not applied");
  AST_WR_SIGDET: assert property (wr_ok && idx == IDX_FIBER_CTRL0 |->
    sigdet_pin_ignore == avs_writedata[9]) else $error("signal detect select not applied");
  AST_TOG_FLIP: assert property (an_event.tx_done |=> $changed(local_np_word.toggle))
    else $error("local toggle did not flip");
  AST_TOG_HOLD: assert property ($changed(local_np_word.toggle) |-> $past(an_event.tx_done))
    else $error("local toggle changed without a sent page");
  AST_IRQ_RISE: assert property ($rose(irq) |-> $past(irq_events != 10'h000) || $past(avs_write))
    else $error("interrupt rose without cause");
endmodule // fiber_an_assertions

bind fiber_autoneg_page_regs fiber_an_assertions u_chk (.clk_sys(clk_sys), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .an_event(an_event), .irq_events(irq_events),
  .sigdet_pin_ignore(sigdet_pin_ignore), .local_np_word(local_np_word), .irq(irq));

// ### verif/partner_an_model.sv
// link partner model: pages, enable state and mode towards the block
`timescale 1ns/1ns
module partner_an_model
  import fiber_an_pkg::*;
(
  input  wire logic clk_sys,
  output an_event_t an_event
);
  initial begin
    an_event = '0;
    an_event.sgmii_mode = 1'b1;
  end
  task automatic mode(input logic sg);
    @(posedge clk_sys);
    an_event.sgmii_mode <= sg;
  endtask
  task automatic page(input logic bp, input np_word_t w);
    np_word_t sent;
    sent = w;
    @(posedge clk_sys);
    if (bp && an_event.sgmii_mode) begin
      sent.more_pages_flag = 1'b0;
    end
    an_event.base_page_rx <= bp;
    an_event.next_page_rx <= !bp;
    an_event.rx_word <= sent;
    @(posedge clk_sys);
    an_event.base_page_rx <= 1'b0;
    an_event.next_page_rx <= 1'b0;
    an_event.rx_word <= ~w; // stale word inverted, never left looking valid
  endtask
  task automatic ctl(input logic en, input logic tx);
    @(posedge clk_sys);
    an_event.enable_state <= en;
    an_event.tx_done <= tx;
    @(posedge clk_sys);
    an_event.enable_state <= 1'b0;
    an_event.tx_done <= 1'b0;
  endtask
endmodule // partner_an_model

// ### verif/test_fiber_autoneg_page_regs.sv
// testbench: registers, page capture and interrupts
`timescale 1ns/1ns
module test_fiber_autoneg_page_regs
  import fiber_an_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [IRQ_N-1:0] irq_events = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sigdet_pin_ignore, irq;
  logic [15:0] rd;
  an_event_t an_event;
  np_word_t local_np_word;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  fiber_autoneg_page_regs dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .an_event(an_event), .irq_events(irq_events),
    .sigdet_pin_ignore(sigdet_pin_ignore), .local_np_word(local_np_word), .irq(irq));
  partner_an_model u_partner (.clk_sys(clk_sys), .an_event(an_event));
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [15:0] wd);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, wd};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [11:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000);
    chk(nm, exp, rd);
  endtask
  task automatic evt(input int b);
    @(posedge clk_sys);
    irq_events[b] <= 1'b1;
    @(posedge clk_sys);
    irq_events[b] <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic t_reset();
    rdc("expansion", IDX_AN_EXPANSION, 16'h0000);
    rdc("local np", IDX_LOCAL_NP, 16'h2001);
    rdc("partner np", IDX_PARTNER_NP, 16'h0000);
    rdc("ctrl0", IDX_FIBER_CTRL0, 16'h0000);
    rdc("mask", IDX_IRQ_MASK, 16'h03ff);
    rdc("unmapped", 12'hc0f, 16'h0000);
  endtask
  task automatic t_writes();
    bus(1'b1, IDX_LOCAL_NP, 16'hffff);
    rdc("local np ones", IDX_LOCAL_NP, 16'hb7ff);
    bus(1'b1, IDX_LOCAL_NP, 16'h0000);
    u_partner.ctl(1'b0, 1'b1);
    rdc("local toggle", IDX_LOCAL_NP, 16'h0800);
    chk("local word", 16'h0800, local_np_word);
    bus(1'b1, IDX_FIBER_CTRL0, 16'hffff);
    rdc("ctrl0 ones", IDX_FIBER_CTRL0, 16'h0200);
    chk("sigdet", 16'h0001, {15'h0, sigdet_pin_ignore});
    bus(1'b1, IDX_AN_EXPANSION, 16'hffff);
    rdc("expansion ro", IDX_AN_EXPANSION, 16'h0000);
  endtask
  task automatic t_pages();
    u_partner.mode(1'b0);
    u_partner.page(1'b1, 16'h8000);
    rdc("exp base", IDX_AN_EXPANSION, 16'h000f);
    rdc("exp reread", IDX_AN_EXPANSION, 16'h000d);
    u_partner.ctl(1'b1, 1'b0);
    rdc("exp enable", IDX_AN_EXPANSION, 16'h0004);
    u_partner.page(1'b0, 16'hb955);
    rdc("partner np", IDX_PARTNER_NP, 16'hb955);
    rdc("exp next", IDX_AN_EXPANSION, 16'h0006);
    u_partner.mode(1'b1);
    u_partner.page(1'b1, 16'h8000);
    rdc("exp sgmii", IDX_AN_EXPANSION, 16'h0003);
  endtask
  task automatic t_irq();
    bus(1'b1, IDX_IRQ_MASK, 16'h03ff);
    for (int i = 0; i < IRQ_N; i++) begin
      evt(i);
      chk("irq set", 16'h0001, {15'h0, irq});
      rdc("pending", IDX_IRQ_PENDING, 16'h0001 << i);
      @(negedge clk_sys);
      chk("irq read", 16'h0000, {15'h0, irq});
    end
    bus(1'b1, IDX_IRQ_MASK, 16'h0000);
    evt(9);
    chk("irq masked", 16'h0000, {15'h0, irq});
    bus(1'b1, IDX_IRQ_MASK, 16'h0200);
    @(negedge clk_sys);
    chk("irq unmask", 16'h0001, {15'h0, irq});
    bus(1'b1, IDX_IRQ_CLEAR, 16'h0200);
    @(negedge clk_sys);
    chk("irq w1c", 16'h0000, {15'h0, irq});
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_writes();
    t_pages();
    t_irq();
    // second reset in mid-run brings the mask back
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rdc("mask again", IDX_IRQ_MASK, 16'h03ff);
    wrap_up();
  end
endmodule // test_fiber_autoneg_page_regs
